// ==== src/prbgp_top.sv ====
// Paged register bank with globals, page select and channel broadcast
`timescale 1ns/100ps
`default_nettype none
module prbgp_top #(
   parameter int WORDS = 16,
   parameter logic [7:0] SC_MASK = 8'h80,
   parameter logic [7:0] RO_MASK = 8'h00
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Byte requests from the serial front end
   input wire prbgp_pkg::prbgp_req_t i_req,
   // Read answer
   output logic [7:0] o_rd_data,
   output logic o_rd_vld,
   // Current selection, for the rest of the chip
   output logic [7:0] o_chan_sel,
   output logic [7:0] o_ctrl
);
   localparam int WAW = $clog2(WORDS);
   localparam int BAW = $clog2(prbgp_pkg::NUM_BANKS);

   function automatic logic is_global(input logic [7:0] a);
      return a >= prbgp_pkg::GLOBAL_LO;
   endfunction

   function automatic logic in_page(input logic [7:0] a);
      return a < 8'(WORDS);
   endfunction

   prbgp_pkg::prbgp_state_t st_r;
   prbgp_pkg::prbgp_state_t st_nxt;
   logic [prbgp_pkg::NUM_BANKS-1:0] wr_banks;
   logic [BAW-1:0] rd_bank;
   logic rd_none;
   logic [7:0] bank_rd;
   logic [7:0] cur;
   logic lane_page;

   assign cur = i_req.addr_vld ? i_req.addr : st_r.ptr;
   assign lane_page = st_r.ctrl[prbgp_pkg::CTRL_PAGE];

   // Page decode for writes and reads
   always_comb begin
      wr_banks = '0;
      rd_bank = '0;
      rd_none = 1'b1;
      if (lane_page) begin
         // Lane page: selected channels, or all of them on broadcast
         for (int c = 0; c < prbgp_pkg::NUM_LANES; c++) begin
            wr_banks[prbgp_pkg::NUM_QUADS + c] = st_r.ctrl[prbgp_pkg::CTRL_BCAST] | st_r.chan_sel[c];
         end
         // Lowest selected channel answers reads
         for (int c = prbgp_pkg::NUM_LANES - 1; c >= 0; c--) begin
            if (st_r.chan_sel[c]) begin
               rd_bank = BAW'(prbgp_pkg::NUM_QUADS + c);
               rd_none = 1'b0;
            end
         end
      end else begin
         // Shared page: quads chosen by the two select bits
         wr_banks[0] = st_r.ctrl[prbgp_pkg::CTRL_Q0];
         wr_banks[1] = st_r.ctrl[prbgp_pkg::CTRL_Q1];
         rd_none = ~(st_r.ctrl[prbgp_pkg::CTRL_Q0] | st_r.ctrl[prbgp_pkg::CTRL_Q1]);
         rd_bank = st_r.ctrl[prbgp_pkg::CTRL_Q0] ? BAW'(0) : BAW'(1);
      end
      if (!(i_req.wr_vld && !is_global(cur) && in_page(cur))) begin
         wr_banks = '0;
      end
   end

   prbgp_bank #(
      .WORDS(WORDS),
      .SC_MASK(SC_MASK),
      .RO_MASK(RO_MASK)
   ) u_bank (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_wr_banks(wr_banks),
      .i_wr_word(cur[WAW-1:0]),
      .i_wr_data(i_req.wr_data),
      .i_rd_bank(rd_bank),
      .i_rd_word(cur[WAW-1:0]),
      .o_rd_data(bank_rd)
   );

   always_comb begin
      st_nxt = st_r;
      st_nxt.rd_vld = 1'b0;
      st_nxt.ptr = cur;
      if (i_req.wr_vld) begin
         // Globals decode the same on either page
         unique case (cur)
            prbgp_pkg::OFS_QUAD_ID: st_nxt.rsvd_ef = i_req.wr_data[7:4];
            prbgp_pkg::OFS_CHAN_SEL: st_nxt.chan_sel = i_req.wr_data;
            prbgp_pkg::OFS_RSVD_FD: st_nxt.rsvd_fd = i_req.wr_data;
            prbgp_pkg::OFS_CTRL: st_nxt.ctrl = i_req.wr_data;
            default: ; // Read-only and unmapped offsets drop the byte
         endcase
         st_nxt.ptr = cur + 8'h01;
      end else if (i_req.rd_req) begin
         st_nxt.rd_vld = 1'b1;
         st_nxt.ptr = cur + 8'h01;
         unique case (cur)
            prbgp_pkg::OFS_QUAD_ID: st_nxt.rd_data = {st_r.rsvd_ef, prbgp_pkg::QUAD_COUNT_CODE};
            prbgp_pkg::OFS_SI_VER: st_nxt.rd_data = {prbgp_pkg::TYPE_FLAG, prbgp_pkg::SI_VERSION};
            prbgp_pkg::OFS_PART_ID: st_nxt.rd_data = prbgp_pkg::PART_IDENTIFIER;
            prbgp_pkg::OFS_LOGIC_REV: st_nxt.rd_data = {prbgp_pkg::LANE_LOGIC_REV, prbgp_pkg::SHARED_LOGIC_REV};
            prbgp_pkg::OFS_CHAN_SEL: st_nxt.rd_data = st_r.chan_sel;
            prbgp_pkg::OFS_RSVD_FD: st_nxt.rd_data = st_r.rsvd_fd;
            prbgp_pkg::OFS_CTRL: st_nxt.rd_data = st_r.ctrl;
            default: begin
               // Unbacked offsets and empty selections read zero
               st_nxt.rd_data = (!is_global(cur) && in_page(cur) && !rd_none) ? bank_rd : 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         st_r <= '{ptr: 8'h00, rsvd_ef: prbgp_pkg::RST_RSVD_EF, chan_sel: prbgp_pkg::RST_CHAN_SEL,
                   rsvd_fd: prbgp_pkg::RST_RSVD_FD, ctrl: prbgp_pkg::RST_CTRL, rd_data: 8'h00, rd_vld: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_rd_data = st_r.rd_data;
   assign o_rd_vld = st_r.rd_vld;
   assign o_chan_sel = st_r.chan_sel;
   assign o_ctrl = st_r.ctrl;

   sequence s_read_at(logic [7:0] a);
      i_req.rd_req && !i_req.wr_vld && cur == a;
   endsequence

   a_part_id_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
      s_read_at(prbgp_pkg::OFS_PART_ID) |=> o_rd_vld && o_rd_data == prbgp_pkg::PART_IDENTIFIER)
      else $error("Part identifier read wrong");
   a_version_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
      s_read_at(prbgp_pkg::OFS_SI_VER) |=> o_rd_data == {prbgp_pkg::TYPE_FLAG, prbgp_pkg::SI_VERSION})
      else $error("Version read wrong");
   a_rev_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
      s_read_at(prbgp_pkg::OFS_LOGIC_REV) |=> o_rd_data == 8'h36)
      else $error("Logic revision read wrong");
   a_quad_id_ro: assert property (@(posedge i_core_clk) disable iff (i_rst)
      s_read_at(prbgp_pkg::OFS_QUAD_ID) |=> o_rd_data == {$past(st_r.rsvd_ef), prbgp_pkg::QUAD_COUNT_CODE})
      else $error("Quad count field not fixed");
   a_ptr_step: assert property (@(posedge i_core_clk) disable iff (i_rst)
      i_req.wr_vld ##1 (i_req.wr_vld && !i_req.addr_vld) |-> cur == $past(cur) + 8'h01)
      else $error("Pointer did not advance");
   a_reset_vals: assert property (@(posedge i_core_clk)
      $past(i_rst) |-> o_chan_sel == 8'h00 && o_ctrl == 8'h10)
      else $error("Reset values wrong");
   a_sel_write: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (i_req.wr_vld && cur == prbgp_pkg::OFS_CHAN_SEL) |=> o_chan_sel == $past(i_req.wr_data))
      else $error("Channel select not stored");
   a_bcast_all: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (i_req.wr_vld && lane_page && st_r.ctrl[1] && cur < 8'(WORDS)) |-> wr_banks == 10'h3fc)
      else $error("Broadcast missed a channel");
   a_shared_map: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (i_req.wr_vld && !lane_page && cur < 8'(WORDS)) |-> wr_banks == {8'h00, st_r.ctrl[5:4]})
      else $error("Shared page mapping wrong");
   a_global_fixed: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (i_req.wr_vld && cur >= 8'hef) |-> wr_banks == '0)
      else $error("Global offset reached a page");
endmodule
`default_nettype wire

// ==== src/prbgp_pkg.sv ====
// Package with offsets, reset values, codes and carrier types of the paged register bank
`default_nettype none
package prbgp_pkg;
   localparam logic [7:0] GLOBAL_LO = 8'hef;
   localparam logic [7:0] OFS_QUAD_ID = 8'hef;
   localparam logic [7:0] OFS_SI_VER = 8'hf0;
   localparam logic [7:0] OFS_PART_ID = 8'hf1;
   localparam logic [7:0] OFS_LOGIC_REV = 8'hf3;
   localparam logic [7:0] OFS_CHAN_SEL = 8'hfc;
   localparam logic [7:0] OFS_RSVD_FD = 8'hfd;
   localparam logic [7:0] OFS_CTRL = 8'hff;
   localparam logic [7:0] RST_CHAN_SEL = 8'h00;
   localparam logic [7:0] RST_RSVD_FD = 8'h00;
   localparam logic [3:0] RST_RSVD_EF = 4'h0;
   localparam logic [7:0] RST_CTRL = 8'h10;
   // Control register field positions
   localparam int CTRL_PAGE = 0;
   localparam int CTRL_BCAST = 1;
   localparam int CTRL_Q0 = 4;
   localparam int CTRL_Q1 = 5;
   // Identity values: arbitrary, chosen only to be distinguishable
   localparam logic [3:0] QUAD_COUNT_CODE = 4'ha;
   localparam logic TYPE_FLAG = 1'h1;
   localparam logic [6:0] SI_VERSION = 7'h15;
   localparam logic [7:0] PART_IDENTIFIER = 8'h5a;
   localparam logic [3:0] LANE_LOGIC_REV = 4'h3;
   localparam logic [3:0] SHARED_LOGIC_REV = 4'h6;
   localparam int NUM_QUADS = 2;
   localparam int NUM_LANES = 8;
   localparam int NUM_BANKS = NUM_QUADS + NUM_LANES;

   // Byte-level request from the serial front end
   typedef struct packed {
      logic addr_vld;
      logic [7:0] addr;
      logic wr_vld;
      logic [7:0] wr_data;
      logic rd_req;
   } prbgp_req_t;

   typedef struct packed {
      logic [7:0] ptr;
      logic [3:0] rsvd_ef;
      logic [7:0] chan_sel;
      logic [7:0] rsvd_fd;
      logic [7:0] ctrl;
      logic [7:0] rd_data;
      logic rd_vld;
   } prbgp_state_t;
endpackage
`default_nettype wire

// ==== src/prbgp_bank.sv ====
// Storage for the shared quad sets and per-channel sets
`timescale 1ns/100ps
`default_nettype none
module prbgp_bank #(
   parameter int WORDS = 16,
   parameter logic [7:0] SC_MASK = 8'h80,
   parameter logic [7:0] RO_MASK = 8'h00
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Write port, one enable per bank
   input wire logic [prbgp_pkg::NUM_BANKS-1:0] i_wr_banks,
   input wire logic [$clog2(WORDS)-1:0] i_wr_word,
   input wire logic [7:0] i_wr_data,
   // Read port
   input wire logic [$clog2(prbgp_pkg::NUM_BANKS)-1:0] i_rd_bank,
   input wire logic [$clog2(WORDS)-1:0] i_rd_word,
   output logic [7:0] o_rd_data
);
   typedef struct packed {
      logic [prbgp_pkg::NUM_BANKS-1:0][WORDS-1:0][7:0] mem;
   } prbgp_bank_state_t;

   prbgp_bank_state_t st_r;
   prbgp_bank_state_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      for (int b = 0; b < prbgp_pkg::NUM_BANKS; b++) begin
         for (int w = 0; w < WORDS; w++) begin
            // Self-clearing bits live one cycle after their write
            st_nxt.mem[b][w] = st_r.mem[b][w] & ~SC_MASK;
         end
         // Separate storage per bank; read-only bits never take writes
         if (i_wr_banks[b]) begin
            st_nxt.mem[b][i_wr_word] = (st_r.mem[b][i_wr_word] & RO_MASK) | (i_wr_data & ~RO_MASK);
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_rd_data = st_r.mem[i_rd_bank][i_rd_word];

   // Any self-clearing bit still set in any bank; a cycle without writes must empty them all
   logic sc_any;
   always_comb begin
      sc_any = 1'b0;
      for (int b = 0; b < prbgp_pkg::NUM_BANKS; b++) begin
         for (int w = 0; w < WORDS; w++) begin
            sc_any = sc_any | (|(st_r.mem[b][w] & SC_MASK));
         end
      end
   end

   a_sc_clears: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (i_wr_banks == '0) |=> !sc_any)
      else $error("Self-clearing bit survived");
   a_ro_kept: assert property (@(posedge i_core_clk) disable iff (i_rst)
      i_wr_banks[2] |=> ((st_r.mem[2][$past(i_wr_word)] & RO_MASK) == 8'h00))
      else $error("Read-only bit took a write");
endmodule
`default_nettype wire

// ==== bench/prbgp_host.sv ====
// Host model issuing byte requests to the paged register bank
`timescale 1ns/100ps
`default_nettype none
module prbgp_host (
   // Clock and read answer
   input wire logic i_core_clk,
   input wire logic [7:0] i_rd_data,
   input wire logic i_rd_vld,
   // Byte requests
   output var prbgp_pkg::prbgp_req_t o_req
);
   initial o_req = '0;
   // Write one byte; pointer is reloaded only on the first byte of a burst
   task automatic wr(input logic av, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_core_clk);
      #1 o_req = '{av, a, 1'b1, d, 1'b0};
   endtask
   task automatic idle();
      @(posedge i_core_clk);
      #1 o_req = '0;
   endtask
   // Read one byte; answer waited for a few cycles only
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      ok = 1'b0;
      d = 8'h00;
      @(posedge i_core_clk);
      #1 o_req = '{1'b1, a, 1'b0, 8'h00, 1'b1};
      @(posedge i_core_clk);
      #1 o_req = '0;
      for (int i = 0; i < 4 && !ok; i++) begin
         if (i_rd_vld === 1'b1) begin
            ok = 1'b1;
            d = i_rd_data;
         end else begin
            @(posedge i_core_clk);
            #1;
         end
      end
   endtask
endmodule
`default_nettype wire

// ==== bench/prbgp_top_test.sv ====
// Self-checking bench for the paged register bank
`timescale 1ns/100ps
`default_nettype none
module prbgp_top_test;
   logic i_core_clk;
   logic i_rst;
   prbgp_pkg::prbgp_req_t req;
   logic [7:0] rd_data, chan_sel, ctrl, d;
   logic rd_vld, ok;
   int fails, total_checks;
   prbgp_top i_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_req(req), .o_rd_data(rd_data),
      .o_rd_vld(rd_vld), .o_chan_sel(chan_sel), .o_ctrl(ctrl));
   prbgp_host i_host (.i_core_clk(i_core_clk), .i_rd_data(rd_data), .i_rd_vld(rd_vld), .o_req(req));
   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end
   task automatic final_report();
      if (fails == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("FAIL %s exp %h got %h", n, e, g);
      end
   endtask
   // A read that never answers counts as a mismatch; the run still ends in the one report
   task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
      i_host.rd(a, d, ok);
      if (ok !== 1'b1) begin
         fails++;
      end
      chk(n, e, d);
   endtask
   task automatic bw(input logic [7:0] a, input int n, input logic [7:0] d0);
      for (int i = 0; i < n; i++) i_host.wr(i == 0, a, d0 + 8'(i));
      i_host.idle();
   endtask
   initial begin
      i_rst = 1'b1;
      fails = 0;
      total_checks = 0;
      repeat (4) @(posedge i_core_clk);
      #1 i_rst = 1'b0;
      rchk("chan_sel", 8'hfc, 8'h00);
      rchk("ctrl", 8'hff, 8'h10);
      rchk("rsvd_fd", 8'hfd, 8'h00);
      // Second pass follows writes of 8'hff to 8'hef and of 8'hfc to 8'hff into 8'hf0 to 8'hf3
      for (int k = 0; k < 2; k++) begin
         rchk("quad_id", 8'hef, {(k == 1) ? 4'hf : 4'h0, prbgp_pkg::QUAD_COUNT_CODE});
         rchk("si_ver", 8'hf0, {prbgp_pkg::TYPE_FLAG, prbgp_pkg::SI_VERSION});
         rchk("part_id", 8'hf1, prbgp_pkg::PART_IDENTIFIER);
         rchk("unmapped", 8'hf2, 8'h00);
         rchk("logic_rev", 8'hf3, {prbgp_pkg::LANE_LOGIC_REV, prbgp_pkg::SHARED_LOGIC_REV});
         bw(8'hef, 1, 8'hff);
         bw(8'hf0, 4, 8'hfc);
      end
      bw(8'hfc, 1, 8'ha5);
      chk("o_chan_sel", 8'ha5, chan_sel);
      rchk("chan_sel", 8'hfc, 8'ha5);
      // Shared page, write quad 0 then quad 1, read back quad 1 then quad 0
      bw(8'hff, 1, 8'h10);
      bw(8'h02, 1, 8'h11);
      bw(8'hff, 1, 8'h20);
      bw(8'h02, 1, 8'h22);
      rchk("q1_word", 8'h02, 8'h22);
      bw(8'hff, 1, 8'h10);
      rchk("q0_word", 8'h02, 8'h11);
      // Turn on lane paging by read, modify, write back
      i_host.rd(8'hff, d, ok);
      bw(8'hff, 1, d | 8'h01);
      chk("o_ctrl", 8'h11, ctrl);
      for (int n = 0; n < 8; n++) begin
         bw(8'hfc, 1, 8'h01 << n);
         bw(8'h03, 1, 8'h40 + 8'(n));
      end
      for (int n = 0; n < 8; n++) begin
         bw(8'hfc, 1, 8'h01 << n);
         rchk("lane_word", 8'h03, 8'h40 + 8'(n));
      end
      rchk("part_id_lane", 8'hf1, prbgp_pkg::PART_IDENTIFIER);
      bw(8'hff, 1, 8'h10);
      rchk("q0_word3", 8'h03, 8'h00);
      // Broadcast write, then read each lane alone
      bw(8'hff, 1, 8'h03);
      bw(8'hfc, 1, 8'h01);
      bw(8'h04, 1, 8'h77);
      for (int n = 0; n < 8; n++) begin
         bw(8'hfc, 1, 8'h01 << n);
         rchk("bcast_word", 8'h04, 8'h77);
      end
      // Back-to-back burst and a self-clearing bit
      bw(8'hff, 1, 8'h01);
      bw(8'h05, 3, 8'h31);
      for (int i = 0; i < 3; i++) rchk("burst_word", 8'h05 + 8'(i), 8'h31 + 8'(i));
      bw(8'h08, 1, 8'h8c);
      rchk("self_clear", 8'h08, 8'h0c);
      bw(8'hfc, 2, 8'h5e);
      chk("o_chan_sel", 8'h5e, chan_sel);
      rchk("rsvd_fd", 8'hfd, 8'h5f);
      final_report();
   end
endmodule
`default_nettype wire
